// *** rtl/bbsc_regs.sv ***
// Register bank for buck3, boost, reference output and backup supply.
// Assumes a decoded 8-bit register port; OTP words steady at reset.
//
// Behaviour
// - Every register is readable at any time and writable, no lockout, save OTP-loaded ones at the first edge after release.
// - OTP-dependent fields reset from OTP content, not fixed constants.
// - Buck3 normal voltage code lives in bits 4:0.
// - Buck3 standby voltage code lives in bits 4:0 of its register.
// - Buck3 sleep voltage code lives in bits 4:0 of its register.
// - Mode bit 5 picks off or sleep after turn-off.
// - Buck3 switching mode selector is mode bits 3:0.
// - Voltage steps 25 mV each 2 us, or 4 us when speed set.
// - Buck3 phase clock select is configuration bits 5:4.
// - Buck3 frequency select is configuration bits 3:2.
// - Configuration bit 0 picks 2.75 A or 2.0 A current limit.
// - Boost standby mode bits 6:5: off, pulse-freq, auto, pulse-skip.
// - Boost normal mode bits 3:2 with the same encoding.
// - Boost voltage bits 1:0, 5.000 V to 5.150 V.
// - Auto mode picks light-load or pulse-skip by load current.
// - Regulator enabled by power-up sequence starts in auto mode.
// - Boost register at 0x66, bits 7 and 4 read zero.
// - Reference output enabled while control bit 0 is one.
// - Backup supply voltage code is bits 2:0.
`timescale 1ns/1ps
`default_nettype none
module bbsc_regs (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] i_otp_buck3_normal,
  input wire logic [7:0] i_otp_buck3_standby,
  input wire logic [7:0] i_otp_buck3_sleep,
  input wire logic [7:0] i_otp_buck3_mode,
  input wire logic [7:0] i_otp_buck3_conf,
  input wire logic [7:0] i_otp_boost,
  input wire logic [7:0] i_otp_backup,
  input wire logic i_standby,
  input wire logic i_sleep,
  input wire logic i_boost_light_load,
  input wire logic i_boost_seq_start,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic [4:0] o_buck3_voltage_code,
  output logic o_buck3_step_busy,
  output logic [3:0] o_buck3_switching_mode_field,
  output logic o_buck3_turnoff_mode_select,
  output logic [1:0] o_buck3_phase_clock_select,
  output logic [1:0] o_buck3_frequency_select,
  output logic o_buck3_current_limit_select,
  output logic [1:0] o_boost_mode_active,
  output logic [1:0] o_boost_output_voltage_code,
  output logic o_reference_output_enable,
  output logic [2:0] o_backup_supply_voltage_code
);
  logic [7:0] b3_normal_reg;
  logic [7:0] b3_standby_reg;
  logic [7:0] b3_sleep_reg;
  logic [7:0] b3_mode_reg;
  logic [7:0] b3_conf_reg;
  logic [7:0] boost_reg;
  logic [7:0] ref_out_reg;
  logic [7:0] backup_reg;
  logic otp_load_reg;
  logic preset_reg;
  logic boost_auto_start;
  bbsc_step_if step_bus ();

  // Next value: OTP load, then host write, else hold
  function automatic logic [7:0] upd(input logic load, input logic [7:0] otp,
                                     input logic wr, input logic [7:0] cur,
                                     input logic [7:0] wd, input logic [7:0] mask);
    logic [7:0] v;
    v = cur;
    if (load) begin
      v = otp & mask;
    end else if (wr) begin
      v = wd & mask;
    end
    return v;
  endfunction : upd

  // No lockout: a write is taken whatever the supply state
  wire wr_normal = i_reg_wr && (i_reg_addr == bbsc_pkg::ADDR_B3_NORMAL);
  wire wr_standby = i_reg_wr && (i_reg_addr == bbsc_pkg::ADDR_B3_STANDBY);
  wire wr_sleep = i_reg_wr && (i_reg_addr == bbsc_pkg::ADDR_B3_SLEEP);
  wire wr_mode = i_reg_wr && (i_reg_addr == bbsc_pkg::ADDR_B3_MODE);
  wire wr_conf = i_reg_wr && (i_reg_addr == bbsc_pkg::ADDR_B3_CONF);
  wire wr_boost = i_reg_wr && (i_reg_addr == bbsc_pkg::ADDR_BOOST);
  wire wr_ref_out = i_reg_wr && (i_reg_addr == bbsc_pkg::ADDR_REF_OUT);
  wire wr_backup = i_reg_wr && (i_reg_addr == bbsc_pkg::ADDR_BACKUP);

  // OTP words replace the reset value at the first edge after release
  wire [7:0] b3_normal_next = upd(otp_load_reg, i_otp_buck3_normal, wr_normal,
    b3_normal_reg, i_reg_wdata, bbsc_pkg::MASK_VOLT);
  wire [7:0] b3_standby_next = upd(otp_load_reg, i_otp_buck3_standby, wr_standby,
    b3_standby_reg, i_reg_wdata, bbsc_pkg::MASK_VOLT);
  wire [7:0] b3_sleep_next = upd(otp_load_reg, i_otp_buck3_sleep, wr_sleep,
    b3_sleep_reg, i_reg_wdata, bbsc_pkg::MASK_VOLT);
  wire [7:0] b3_mode_next = upd(otp_load_reg, i_otp_buck3_mode, wr_mode,
    b3_mode_reg, i_reg_wdata, bbsc_pkg::MASK_MODE);
  wire [7:0] b3_conf_next = upd(otp_load_reg, i_otp_buck3_conf, wr_conf,
    b3_conf_reg, i_reg_wdata, bbsc_pkg::MASK_CONF);
  wire [7:0] boost_next = upd(otp_load_reg, i_otp_boost, wr_boost,
    boost_reg, i_reg_wdata, bbsc_pkg::MASK_BOOST);
  // Reference control has no OTP default, so it keeps its constant
  wire [7:0] ref_out_next = upd(1'b0, bbsc_pkg::RST_REF_OUT, wr_ref_out,
    ref_out_reg, i_reg_wdata, bbsc_pkg::MASK_REF_OUT);
  wire [7:0] backup_next = upd(otp_load_reg, i_otp_backup, wr_backup,
    backup_reg, i_reg_wdata, bbsc_pkg::MASK_BACKUP);

  // Unmapped addresses read as zero
  wire [7:0] rd_mux =
    (i_reg_addr == bbsc_pkg::ADDR_B3_NORMAL) ? b3_normal_reg :
    (i_reg_addr == bbsc_pkg::ADDR_B3_STANDBY) ? b3_standby_reg :
    (i_reg_addr == bbsc_pkg::ADDR_B3_SLEEP) ? b3_sleep_reg :
    (i_reg_addr == bbsc_pkg::ADDR_B3_MODE) ? b3_mode_reg :
    (i_reg_addr == bbsc_pkg::ADDR_B3_CONF) ? b3_conf_reg :
    (i_reg_addr == bbsc_pkg::ADDR_BOOST) ? boost_reg :
    (i_reg_addr == bbsc_pkg::ADDR_REF_OUT) ? ref_out_reg :
    (i_reg_addr == bbsc_pkg::ADDR_BACKUP) ? backup_reg : 8'h00;
  wire [7:0] rdata_next = i_reg_rd ? rd_mux : o_reg_rdata;

  // Sleep takes priority over standby for the active target
  wire [4:0] b3_target = i_sleep ? b3_sleep_reg[4:0] :
    i_standby ? b3_standby_reg[4:0] : b3_normal_reg[4:0];
  wire [1:0] boost_sel = i_standby ? boost_reg[6:5] : boost_reg[3:2];

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      b3_normal_reg <= bbsc_pkg::RST_REG;
      b3_standby_reg <= bbsc_pkg::RST_REG;
      b3_sleep_reg <= bbsc_pkg::RST_REG;
      b3_mode_reg <= bbsc_pkg::RST_REG;
      b3_conf_reg <= bbsc_pkg::RST_REG;
      boost_reg <= bbsc_pkg::RST_REG;
      ref_out_reg <= bbsc_pkg::RST_REF_OUT;
      backup_reg <= bbsc_pkg::RST_REG;
    end else begin
      b3_normal_reg <= b3_normal_next;
      b3_standby_reg <= b3_standby_next;
      b3_sleep_reg <= b3_sleep_next;
      b3_mode_reg <= b3_mode_next;
      b3_conf_reg <= b3_conf_next;
      boost_reg <= boost_next;
      ref_out_reg <= ref_out_next;
      backup_reg <= backup_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      otp_load_reg <= 1'b1;
      preset_reg <= 1'b0;
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      otp_load_reg <= 1'b0;
      preset_reg <= otp_load_reg;
      o_reg_rdata <= rdata_next;
      o_reg_rvalid <= i_reg_rd;
    end
  end

  // Stepper jumps straight to the OTP code once, then ramps
  assign step_bus.target = b3_target;
  assign step_bus.slow = b3_conf_reg[bbsc_pkg::B3_SPEED_BIT];
  assign step_bus.preset = preset_reg;

  bbsc_dvs_stepper u_stepper (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .s(step_bus.step)
  );

  bbsc_boost_mode u_boost_mode (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_mode_sel(boost_sel),
    .i_light_load(i_boost_light_load),
    .i_seq_start(i_boost_seq_start),
    .i_mode_written(wr_boost),
    .o_mode_active(o_boost_mode_active),
    .o_auto_start(boost_auto_start)
  );

  assign o_buck3_voltage_code = step_bus.current;
  assign o_buck3_step_busy = step_bus.busy;
  assign o_buck3_switching_mode_field = b3_mode_reg[3:0];
  assign o_buck3_turnoff_mode_select = b3_mode_reg[bbsc_pkg::B3_OMODE_BIT];
  assign o_buck3_phase_clock_select = b3_conf_reg[5:4];
  assign o_buck3_frequency_select = b3_conf_reg[3:2];
  assign o_buck3_current_limit_select = b3_conf_reg[bbsc_pkg::B3_ILIM_BIT];
  assign o_boost_output_voltage_code = boost_reg[1:0];
  assign o_reference_output_enable = ref_out_reg[bbsc_pkg::REF_OUT_EN_BIT];
  assign o_backup_supply_voltage_code = backup_reg[2:0];

  // Checking helpers: cycles since the code moved, restarted while idle
  logic [9:0] gap_reg;
  logic [4:0] cur_d_reg;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap_reg <= 10'h000;
      cur_d_reg <= 5'h00;
    end else begin
      cur_d_reg <= step_bus.current;
      gap_reg <= (step_bus.current != cur_d_reg || !step_bus.busy) ? 10'h001 :
        gap_reg + 10'h001;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_write(logic [7:0] a);
    i_reg_wr && !otp_load_reg && i_reg_addr == a;
  endsequence
  sequence s_read(logic [7:0] a);
    i_reg_rd && i_reg_addr == a;
  endsequence

  property p_read_back;
    s_read(bbsc_pkg::ADDR_B3_CONF) |=> o_reg_rvalid && o_reg_rdata == $past(b3_conf_reg);
  endproperty
  a_read_back: assert property (p_read_back) else $error("conf read mismatch");

  property p_otp_load;
    otp_load_reg |=> b3_normal_reg == ($past(i_otp_buck3_normal) & 8'h1f);
  endproperty
  a_otp_load: assert property (p_otp_load) else $error("OTP not loaded");

  property p_normal_wr;
    s_write(bbsc_pkg::ADDR_B3_NORMAL) |=> b3_normal_reg == {3'h0, $past(i_reg_wdata[4:0])};
  endproperty
  a_normal_wr: assert property (p_normal_wr) else $error("normal code wrong");

  property p_standby_wr;
    s_write(bbsc_pkg::ADDR_B3_STANDBY) ##1 !i_reg_wr ##1 s_read(bbsc_pkg::ADDR_B3_STANDBY)
      |=> o_reg_rdata == {3'h0, $past(i_reg_wdata[4:0], 3)};
  endproperty
  a_standby_wr: assert property (p_standby_wr) else $error("standby code wrong");

  property p_sleep_target;
    s_write(bbsc_pkg::ADDR_B3_SLEEP) ##1 (i_sleep && !preset_reg)
      |-> step_bus.target == $past(i_reg_wdata[4:0]);
  endproperty
  a_sleep_target: assert property (p_sleep_target) else $error("sleep target wrong");

  property p_mode_bits;
    s_write(bbsc_pkg::ADDR_B3_MODE) |=> o_buck3_turnoff_mode_select == $past(i_reg_wdata[5])
      && o_buck3_switching_mode_field == $past(i_reg_wdata[3:0]);
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode fields wrong");

  property p_step_gap_min;
    (step_bus.current != cur_d_reg) && !$past(preset_reg)
      |-> gap_reg >= bbsc_pkg::STEP_FAST_CYC;
  endproperty
  a_step_gap_min: assert property (p_step_gap_min) else $error("step too fast");

  property p_step_gap_max;
    step_bus.busy |-> gap_reg <= bbsc_pkg::STEP_SLOW_CYC + 10'h001;
  endproperty
  a_step_gap_max: assert property (p_step_gap_max) else $error("step too slow");

  property p_conf_bits;
    s_write(bbsc_pkg::ADDR_B3_CONF) |=> o_buck3_phase_clock_select == $past(i_reg_wdata[5:4])
      && o_buck3_frequency_select == $past(i_reg_wdata[3:2])
      && o_buck3_current_limit_select == $past(i_reg_wdata[0]);
  endproperty
  a_conf_bits: assert property (p_conf_bits) else $error("conf fields wrong");

  property p_boost_fixed;
    !boost_auto_start && boost_sel != bbsc_pkg::BOOST_AUTO
      |=> o_boost_mode_active == $past(boost_sel);
  endproperty
  a_boost_fixed: assert property (p_boost_fixed) else $error("boost mode wrong");

  property p_boost_volt;
    s_write(bbsc_pkg::ADDR_BOOST) |=> o_boost_output_voltage_code == $past(i_reg_wdata[1:0]);
  endproperty
  a_boost_volt: assert property (p_boost_volt) else $error("boost volt wrong");

  property p_auto_pick;
    (boost_auto_start || boost_sel == bbsc_pkg::BOOST_AUTO) && i_boost_light_load
      |=> o_boost_mode_active == bbsc_pkg::BOOST_PFREQ;
  endproperty
  a_auto_pick: assert property (p_auto_pick) else $error("auto not pulse-freq");

  property p_seq_auto;
    i_boost_seq_start |=> boost_auto_start ##1 o_boost_mode_active != bbsc_pkg::BOOST_OFF;
  endproperty
  a_seq_auto: assert property (p_seq_auto) else $error("no auto start");

  property p_boost_reserved;
    boost_reg[7] == 1'b0 && boost_reg[4] == 1'b0;
  endproperty
  a_boost_reserved: assert property (p_boost_reserved) else $error("boost reserved set");

  property p_ref_out;
    s_write(bbsc_pkg::ADDR_REF_OUT) |=> o_reference_output_enable == $past(i_reg_wdata[0]);
  endproperty
  a_ref_out: assert property (p_ref_out) else $error("ref out enable wrong");

  property p_backup;
    s_write(bbsc_pkg::ADDR_BACKUP) |=> o_backup_supply_voltage_code == $past(i_reg_wdata[2:0]);
  endproperty
  a_backup: assert property (p_backup) else $error("backup code wrong");

  property p_unmapped;
    s_read(8'h50) |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");

  property p_auto_skip;
    (boost_auto_start || boost_sel == bbsc_pkg::BOOST_AUTO) && !i_boost_light_load
      |=> o_boost_mode_active == bbsc_pkg::BOOST_PSKIP;
  endproperty
  a_auto_skip: assert property (p_auto_skip) else $error("auto not pulse-skip");

  property p_auto_clear;
    boost_auto_start && wr_boost && !i_boost_seq_start |=> !boost_auto_start;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto flag stuck");

  property p_rvalid_idle;
    !i_reg_rd |=> !o_reg_rvalid;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("stray read valid");

  property p_ref_out_reset;
    otp_load_reg && !wr_ref_out |=> !o_reference_output_enable;
  endproperty
  a_ref_out_reset: assert property (p_ref_out_reset) else $error("ref out set");

  property p_backup_otp;
    otp_load_reg |=> backup_reg == ($past(i_otp_backup) & bbsc_pkg::MASK_BACKUP);
  endproperty
  a_backup_otp: assert property (p_backup_otp) else $error("backup OTP not loaded");

  property p_idle_hold;
    !step_bus.busy && !step_bus.preset |=> step_bus.current == $past(step_bus.current);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("code moved while idle");
endmodule : bbsc_regs
`default_nettype wire

// *** rtl/bbsc_pkg.sv ***
// Constants for the buck3 / boost / reference / backup register slice.
// Assumes an 8-bit register port fed by the control-interface decoder.
package bbsc_pkg;
  localparam logic [7:0] ADDR_B3_NORMAL = 8'h4a;
  localparam logic [7:0] ADDR_B3_STANDBY = 8'h4b;
  localparam logic [7:0] ADDR_B3_SLEEP = 8'h4c;
  localparam logic [7:0] ADDR_B3_MODE = 8'h4d;
  localparam logic [7:0] ADDR_B3_CONF = 8'h4e;
  localparam logic [7:0] ADDR_BOOST = 8'h66;
  localparam logic [7:0] ADDR_REF_OUT = 8'h6a;
  localparam logic [7:0] ADDR_BACKUP = 8'h6b;
  localparam logic [7:0] MASK_VOLT = 8'h1f;
  localparam logic [7:0] MASK_MODE = 8'h2f;
  localparam logic [7:0] MASK_CONF = 8'h7d;
  localparam logic [7:0] MASK_BOOST = 8'h6f;
  localparam logic [7:0] MASK_REF_OUT = 8'h01;
  localparam logic [7:0] MASK_BACKUP = 8'h07;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_REF_OUT = 8'h00;
  localparam int B3_OMODE_BIT = 5;
  localparam int B3_SPEED_BIT = 6;
  localparam int B3_ILIM_BIT = 0;
  localparam int REF_OUT_EN_BIT = 0;
  localparam logic [1:0] BOOST_OFF = 2'h0;
  localparam logic [1:0] BOOST_PFREQ = 2'h1;
  localparam logic [1:0] BOOST_AUTO = 2'h2;
  localparam logic [1:0] BOOST_PSKIP = 2'h3;
  localparam int CLK_PERIOD_NS = 8;
  localparam int STEP_FAST_NS = 2000;
  localparam int STEP_SLOW_NS = 4000;
  localparam logic [9:0] STEP_FAST_CYC =
    10'((STEP_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] STEP_SLOW_CYC =
    10'((STEP_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE = 10'h001;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_STEP = 1'b1
  } bbsc_step_state_e;
endpackage : bbsc_pkg

// *** rtl/bbsc_step_if.sv ***
// Link between the register bank and the buck3 voltage stepper.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface bbsc_step_if;
  logic [4:0] target;
  logic slow;
  logic preset;
  logic [4:0] current;
  logic busy;
  modport ctrl (output target, output slow, output preset,
                input current, input busy);
  modport step (input target, input slow, input preset,
                output current, output busy);
endinterface : bbsc_step_if
`default_nettype wire

// *** rtl/bbsc_dvs_stepper.sv ***
// Buck3 voltage stepper: walks the code one step per period to target.
// Assumes target is steady for a period at a time.
`timescale 1ns/1ps
`default_nettype none
module bbsc_dvs_stepper (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  bbsc_step_if.step s
);
  bbsc_pkg::bbsc_step_state_e state_reg;
  logic [9:0] cnt_reg;
  logic [4:0] cur_reg;
  wire [9:0] period = s.slow ? bbsc_pkg::STEP_SLOW_CYC : bbsc_pkg::STEP_FAST_CYC;
  wire differ = (cur_reg != s.target);
  wire up = (s.target > cur_reg);
  wire [4:0] stepped = up ? cur_reg + 5'h01 : cur_reg - 5'h01;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= bbsc_pkg::ST_IDLE;
      cnt_reg <= bbsc_pkg::CNT_ZERO;
      cur_reg <= 5'h00;
    end else if (s.preset) begin
      state_reg <= bbsc_pkg::ST_IDLE;
      cnt_reg <= bbsc_pkg::CNT_ZERO;
      cur_reg <= s.target;
    end else begin
      case (state_reg)
        bbsc_pkg::ST_IDLE: begin
          if (differ) begin
            state_reg <= bbsc_pkg::ST_STEP;
            cnt_reg <= bbsc_pkg::CNT_ONE;
          end
        end
        bbsc_pkg::ST_STEP: begin
          if (!differ) begin
            state_reg <= bbsc_pkg::ST_IDLE;
            cnt_reg <= bbsc_pkg::CNT_ZERO;
          end else if (cnt_reg >= period) begin
            // One code step per period, 25 mV each
            cur_reg <= stepped;
            cnt_reg <= bbsc_pkg::CNT_ONE;
          end else begin
            cnt_reg <= cnt_reg + bbsc_pkg::CNT_ONE;
          end
        end
        default: begin
          state_reg <= bbsc_pkg::ST_IDLE;
        end
      endcase
    end
  end
  assign s.current = cur_reg;
  assign s.busy = (state_reg == bbsc_pkg::ST_STEP);
endmodule : bbsc_dvs_stepper
`default_nettype wire

// *** rtl/bbsc_boost_mode.sv ***
// Boost switching-mode resolver: auto picks light-load or pulse-skip.
// Assumes the load hint is already synchronous.
`timescale 1ns/1ps
`default_nettype none
module bbsc_boost_mode (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [1:0] i_mode_sel,
  input wire logic i_light_load,
  input wire logic i_seq_start,
  input wire logic i_mode_written,
  output logic [1:0] o_mode_active,
  output logic o_auto_start
);
  // Sequencer start wins over a simultaneous host write
  wire start_next = i_seq_start | (o_auto_start & ~i_mode_written);
  wire [1:0] sel_eff = o_auto_start ? bbsc_pkg::BOOST_AUTO : i_mode_sel;
  wire [1:0] auto_pick = i_light_load ? bbsc_pkg::BOOST_PFREQ : bbsc_pkg::BOOST_PSKIP;
  wire [1:0] mode_next = (sel_eff == bbsc_pkg::BOOST_AUTO) ? auto_pick : sel_eff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mode_active <= bbsc_pkg::BOOST_OFF;
      o_auto_start <= 1'b0;
    end else begin
      o_mode_active <= mode_next;
      o_auto_start <= start_next;
    end
  end
endmodule : bbsc_boost_mode
`default_nettype wire

// *** testbench/bbsc_host_model.sv ***
// Host model: drives the slice's register port.
// Assumes read data and valid come one edge after a read.
`timescale 1ns/1ps
`default_nettype none
module bbsc_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output var logic o_reg_wr,
  output var logic o_reg_rd,
  output var logic [7:0] o_reg_addr,
  output var logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // Idle lines flip so a stale address never passes for a live one
  task automatic release_bus;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = ~o_reg_addr;
    o_reg_wdata = ~o_reg_wdata;
  endtask : release_bus
  // No mode check before access; callers also pass the unmapped address 8'h50 and data with reserved bits set
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    #1;
    o_reg_addr = addr;
    o_reg_wdata = data;
    o_reg_wr = 1'b1;
    @(posedge i_sys_clk);
    #1;
    release_bus();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(posedge i_sys_clk);
    #1;
    o_reg_addr = addr;
    o_reg_rd = 1'b1;
    @(posedge i_sys_clk);
    #1;
    release_bus();
    valid = i_reg_rvalid;
    data = i_reg_rdata;
  endtask : read_reg
endmodule : bbsc_host_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Testbench for the buck3 / boost / reference / backup register slice.
// Assumes the host model owns the register port; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LIMIT = 20000;
  logic i_sys_clk;
  logic i_reset_n;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic standby;
  logic sleep;
  logic light_load;
  logic seq_start;
  logic [4:0] volt_code;
  logic step_busy;
  logic [3:0] sw_mode;
  logic turnoff;
  logic [1:0] phase;
  logic [1:0] freq;
  logic ilim;
  logic [1:0] boost_active;
  logic [1:0] boost_volt;
  logic ref_en;
  logic [2:0] backup_code;
  logic [15:0] cfg_out;
  int fail_count;
  int checked;
  int cycles;
  logic [7:0] addr_tab [8] = '{bbsc_pkg::ADDR_B3_NORMAL, bbsc_pkg::ADDR_B3_STANDBY,
    bbsc_pkg::ADDR_B3_SLEEP, bbsc_pkg::ADDR_B3_MODE, bbsc_pkg::ADDR_B3_CONF,
    bbsc_pkg::ADDR_BOOST, bbsc_pkg::ADDR_REF_OUT, bbsc_pkg::ADDR_BACKUP};
  logic [7:0] mask_tab [8] = '{bbsc_pkg::MASK_VOLT, bbsc_pkg::MASK_VOLT, bbsc_pkg::MASK_VOLT,
    bbsc_pkg::MASK_MODE, bbsc_pkg::MASK_CONF, bbsc_pkg::MASK_BOOST, bbsc_pkg::MASK_REF_OUT,
    bbsc_pkg::MASK_BACKUP};
  // Standby code sits one step from normal and sleep code two, to keep ramps short
  logic [7:0] otp_tab [8] = '{8'hf3, 8'hf4, 8'h35, 8'hff, 8'hbf, 8'h96, 8'hff, 8'hfa};
  logic [7:0] pat [2] = '{8'hfb, 8'h04};
  assign cfg_out = {sw_mode, turnoff, phase, freq, ilim, boost_volt, ref_en, backup_code};

  bbsc_host_model i_bbsc_host_model (.i_sys_clk(i_sys_clk), .i_reg_rdata(reg_rdata),
    .i_reg_rvalid(reg_rvalid), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata));
  bbsc_regs i_bbsc_regs (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_otp_buck3_normal(otp_tab[0]), .i_otp_buck3_standby(otp_tab[1]),
    .i_otp_buck3_sleep(otp_tab[2]), .i_otp_buck3_mode(otp_tab[3]),
    .i_otp_buck3_conf(otp_tab[4]), .i_otp_boost(otp_tab[5]), .i_otp_backup(otp_tab[7]),
    .i_standby(standby), .i_sleep(sleep), .i_boost_light_load(light_load),
    .i_boost_seq_start(seq_start), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
    .o_buck3_voltage_code(volt_code), .o_buck3_step_busy(step_busy),
    .o_buck3_switching_mode_field(sw_mode), .o_buck3_turnoff_mode_select(turnoff),
    .o_buck3_phase_clock_select(phase), .o_buck3_frequency_select(freq),
    .o_buck3_current_limit_select(ilim), .o_boost_mode_active(boost_active),
    .o_boost_output_voltage_code(boost_volt), .o_reference_output_enable(ref_en),
    .o_backup_supply_voltage_code(backup_code));

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    i_bbsc_host_model.read_reg(addr, d, v);
    check({7'h00, v, d}, {8'h01, exp});
  endtask : rd_check

  task automatic do_reset;
    i_reset_n = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    repeat (2) @(posedge i_sys_clk);
  endtask : do_reset

  // Step edges counted from a settled point; a few cycles of slack
  task automatic step_wait(input logic [4:0] code, input int period);
    int n;
    n = 0;
    while (volt_code !== code && n < 2000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check({15'h0000, (n >= period - 4 && n <= period + 4)}, 16'h0001);
  endtask : step_wait

  initial begin
    fail_count = 0;
    checked = 0;
    cycles = 0;
    i_reset_n = 1'b0;
    standby = 1'b0;
    sleep = 1'b0;
    light_load = 1'b1;
    seq_start = 1'b0;
    do_reset();
    for (int i = 0; i < 8; i++) begin
      rd_check(addr_tab[i], (i == 6) ? 8'h00 : otp_tab[i] & mask_tab[i]);
    end
    check({11'h000, volt_code}, 16'h0013);
    check(cfg_out, {4'hf, 1'b1, 2'h3, 2'h3, 1'b1, 2'h2, 1'b0, 3'h2});
    $display("Test reset_values done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        i_bbsc_host_model.write_reg(addr_tab[i], pat[p]);
        rd_check(addr_tab[i], pat[p] & mask_tab[i]);
      end
      check(cfg_out, (p == 0) ? {4'hb, 1'b1, 2'h3, 2'h2, 1'b1, 2'h3, 1'b1, 3'h3} :
        {4'h4, 1'b0, 2'h0, 2'h1, 1'b0, 2'h0, 1'b0, 3'h4});
    end
    i_bbsc_host_model.write_reg(8'h50, 8'hff);
    rd_check(8'h50, 8'h00);
    rd_check(bbsc_pkg::ADDR_BACKUP, 8'h04);
    $display("Test readback done");
    // Second reset mid-run also returns the OTP defaults
    do_reset();
    i_bbsc_host_model.write_reg(bbsc_pkg::ADDR_B3_NORMAL, 8'h15);
    repeat (3) @(posedge i_sys_clk);
    #1;
    check({15'h0000, step_busy}, 16'h0001);
    step_wait(5'h14, 247);
    step_wait(5'h15, 250);
    repeat (2) @(posedge i_sys_clk);
    #1;
    check({15'h0000, step_busy}, 16'h0000);
    i_bbsc_host_model.write_reg(bbsc_pkg::ADDR_B3_CONF, 8'h7d);
    i_bbsc_host_model.write_reg(bbsc_pkg::ADDR_B3_NORMAL, 8'h14);
    step_wait(5'h14, 501);
    i_bbsc_host_model.write_reg(bbsc_pkg::ADDR_B3_SLEEP, 8'h15);
    sleep = 1'b1;
    standby = 1'b1;
    step_wait(5'h15, 501);
    sleep = 1'b0;
    step_wait(5'h14, 501);
    $display("Test voltage_steps done");
    for (int s = 0; s < 2; s++) begin
      for (int l = 0; l < 2; l++) begin
        for (int m = 0; m < 4; m++) begin
          standby = s[0];
          light_load = l[0];
          i_bbsc_host_model.write_reg(bbsc_pkg::ADDR_BOOST,
            (s == 1) ? {1'b0, m[1:0], 5'h00} : {4'h0, m[1:0], 2'h0});
          repeat (3) @(posedge i_sys_clk);
          #1;
          check({14'h0000, boost_active},
            {14'h0000, (m == 2) ? ((l == 1) ? 2'h1 : 2'h3) : m[1:0]});
        end
      end
    end
    $display("Test boost_modes done");
    standby = 1'b0;
    i_bbsc_host_model.write_reg(bbsc_pkg::ADDR_BOOST, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    #1;
    seq_start = 1'b1;
    @(posedge i_sys_clk);
    #1;
    seq_start = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    check({14'h0000, boost_active}, 16'h0001);
    i_bbsc_host_model.write_reg(bbsc_pkg::ADDR_BOOST, 8'h0c);
    repeat (3) @(posedge i_sys_clk);
    #1;
    check({14'h0000, boost_active}, 16'h0003);
    $display("Test sequence_start done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
